// ### core/dacrp_pkg.sv
// package: register map, defaults, frame layout and link types for the dac control port
package dacrp_pkg;

  localparam int unsigned REG_AW        = 5;
  localparam int unsigned REG_DW        = 8;
  localparam int unsigned REG_COUNT     = 15;

  localparam logic [4:0] MAIN_CONTROL_OFFS           = 5'h00;
  localparam logic [4:0] FILTER_SPEED_CONTROL_OFFS   = 5'h01;
  localparam logic [4:0] POWER_POLARITY_CONTROL_OFFS = 5'h02;
  localparam logic [4:0] LEFT1_VOLUME_OFFS           = 5'h03;
  localparam logic [4:0] RIGHT1_VOLUME_OFFS          = 5'h04;
  localparam logic [4:0] LEFT2_VOLUME_OFFS           = 5'h05;
  localparam logic [4:0] RIGHT2_VOLUME_OFFS          = 5'h06;
  localparam logic [4:0] LEFT3_VOLUME_OFFS           = 5'h07;
  localparam logic [4:0] RIGHT3_VOLUME_OFFS          = 5'h08;
  localparam logic [4:0] RESERVED_A_OFFS             = 5'h09;
  localparam logic [4:0] RESERVED_B_OFFS             = 5'h0a;
  localparam logic [4:0] OUTPUT_POLARITY_OFFS        = 5'h0b;
  localparam logic [4:0] ZERO_FLAG1_SELECT_OFFS      = 5'h0c;
  localparam logic [4:0] ZERO_FLAG2_SELECT_OFFS      = 5'h0d;
  localparam logic [4:0] EMPHASIS_ENABLE_OFFS        = 5'h0e;

  localparam logic [7:0] MAIN_CONTROL_RST           = 8'h8b;
  localparam logic [7:0] FILTER_SPEED_CONTROL_RST   = 8'h02;
  localparam logic [7:0] POWER_POLARITY_CONTROL_RST = 8'h62;
  localparam logic [7:0] VOLUME_RST                 = 8'hff;
  localparam logic [7:0] RESERVED_RST               = 8'hff;
  localparam logic [7:0] ZERO_RST                   = 8'h00;

  // writable bits per register; constant-zero bits stay zero
  localparam logic [7:0] MAIN_CONTROL_MASK           = 8'hff;
  localparam logic [7:0] FILTER_SPEED_CONTROL_MASK   = 8'h3f;
  localparam logic [7:0] POWER_POLARITY_CONTROL_MASK = 8'h66;
  localparam logic [7:0] VOLUME_MASK                 = 8'hff;
  localparam logic [7:0] LANE_SELECT_MASK            = 8'hfc;
  localparam logic [7:0] EMPHASIS_ENABLE_MASK        = 8'h0e;

  localparam int unsigned DAC1_POWER_UP_POS    = 1;
  localparam int unsigned TIMING_RESET_BIT_POS = 0;

  // 3-wire frame: 2 chip bits, 1 direction bit, 5 address bits, 8 data bits
  localparam int unsigned SER_FRAME_BITS  = 16;
  localparam logic        SER_CHIP_LOW    = 1'b1;
  localparam logic        SER_DIR_WRITE   = 1'b1;

  // two-wire slave address prefix; value is arbitrary
  localparam logic [4:0] I2C_ADDR_PREFIX = 5'h0a;

  typedef struct packed {
    logic       valid;
    logic [4:0] addr;
    logic [7:0] data;
  } dacrp_wr_t;

  typedef struct packed {
    logic main_control;
    logic filter_speed_control;
    logic power_polarity_control;
    logic [7:0] left1_volume;
  } dacrp_unused_t;

endpackage : dacrp_pkg

// ### core/dacrp_serial_rx.sv
// 3-wire serial write receiver: shifts frames on clock rises, commits on select rise
`timescale 1ns/1ps
module dacrp_serial_rx (
  input  wire logic              core_clk_i,
  input  wire logic              arst_n_i,
  input  wire logic              enable_i,
  input  wire logic              chip_addr_pin_high_i,
  input  wire logic              sel_n_i,
  input  wire logic              sclk_i,
  input  wire logic              sdat_i,
  output dacrp_pkg::dacrp_wr_t   wr_o
);

  typedef struct packed {
    logic        sel_q;
    logic        clk_q;
    logic [15:0] shreg;
    logic [4:0]  cnt;
    dacrp_pkg::dacrp_wr_t wr;
  } dacrp_ser_st_t;

  dacrp_ser_st_t st;
  dacrp_ser_st_t next_st;
  logic          frame_ok;

  always_comb begin
    next_st       = st;
    next_st.sel_q = sel_n_i;
    next_st.clk_q = sclk_i;
    next_st.wr    = '0;
    frame_ok      = (st.shreg[15] == chip_addr_pin_high_i)
                    && (st.shreg[14] == dacrp_pkg::SER_CHIP_LOW)
                    && (st.shreg[13] == dacrp_pkg::SER_DIR_WRITE)
                    && (st.cnt >= 5'(dacrp_pkg::SER_FRAME_BITS));
    if (sel_n_i) begin
      next_st.cnt = '0;
    end else if (sclk_i && !st.clk_q) begin
      // sample on rising control clock, msb first
      next_st.shreg = {st.shreg[14:0], sdat_i};
      if (st.cnt != 5'h1f) begin
        next_st.cnt = st.cnt + 5'h01;
      end
    end
    if (sel_n_i && !st.sel_q && enable_i && frame_ok) begin
      next_st.wr.valid = 1'b1;
      next_st.wr.addr  = st.shreg[12:8];
      next_st.wr.data  = st.shreg[7:0];
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      // control clock idles high; a zero here would fake a rising edge after reset
      st <= '{sel_q: 1'b1, clk_q: 1'b1, default: '0};
    end else begin
      st <= next_st;
    end
  end

  assign wr_o = st.wr;

endmodule : dacrp_serial_rx

// ### core/dacrp_i2c_rx.sv
// two-wire write-only slave receiver with address auto-increment
`timescale 1ns/1ps
module dacrp_i2c_rx (
  input  wire logic              core_clk_i,
  input  wire logic              arst_n_i,
  input  wire logic              enable_i,
  input  wire logic [1:0]        chip_addr_i,
  input  wire logic              scl_i,
  input  wire logic              sda_i,
  output logic                   sda_oe_o,
  output dacrp_pkg::dacrp_wr_t   wr_o
);

  typedef enum logic [4:0] {
    I_IDLE = 5'b00001,
    I_ADDR = 5'b00010,
    I_REG  = 5'b00100,
    I_DATA = 5'b01000,
    I_ACK  = 5'b10000
  } dacrp_i2c_state_t;

  typedef struct packed {
    dacrp_i2c_state_t state;
    dacrp_i2c_state_t after_ack;
    logic       scl_q;
    logic       sda_q;
    logic [7:0] shreg;
    logic [3:0] bits;
    logic [4:0] addr_ctr;
    logic       ack_drive;
    dacrp_pkg::dacrp_wr_t wr;
  } dacrp_i2c_st_t;

  dacrp_i2c_st_t st;
  dacrp_i2c_st_t next_st;
  logic          scl_rise;
  logic          scl_fall;
  logic [7:0]    byte_in;

  always_comb begin
    next_st       = st;
    next_st.scl_q = scl_i;
    next_st.sda_q = sda_i;
    next_st.wr    = '0;
    scl_rise      = scl_i && !st.scl_q;
    scl_fall      = !scl_i && st.scl_q;
    byte_in       = {st.shreg[6:0], sda_i};
    if (!enable_i) begin
      next_st.state     = I_IDLE;
      next_st.ack_drive = 1'b0;
    end else if (scl_i && st.scl_q && st.sda_q && !sda_i) begin
      next_st.state     = I_ADDR; // start or repeated start
      next_st.bits      = '0;
      next_st.ack_drive = 1'b0;
    end else if (scl_i && st.scl_q && !st.sda_q && sda_i) begin
      next_st.state     = I_IDLE; // stop
      next_st.ack_drive = 1'b0;
    end else begin
      case (st.state)
        I_IDLE: begin
          next_st.ack_drive = 1'b0;
        end
        I_ADDR, I_REG, I_DATA: begin
          if (scl_rise) begin
            next_st.shreg = byte_in;
            next_st.bits  = st.bits + 4'h1;
            if (st.bits == 4'h7) begin
              next_st.bits = '0;
              case (st.state)
                I_ADDR: begin
                  // a read direction is left unacknowledged
                  if (byte_in == {dacrp_pkg::I2C_ADDR_PREFIX, chip_addr_i, 1'b0}) begin
                    next_st.state     = I_ACK;
                    next_st.after_ack = I_REG;
                  end else begin
                    next_st.state = I_IDLE;
                  end
                end
                I_REG: begin
                  next_st.addr_ctr  = byte_in[4:0];
                  next_st.state     = I_ACK;
                  next_st.after_ack = I_DATA;
                end
                default: begin
                  next_st.wr.valid  = 1'b1;
                  next_st.wr.addr   = st.addr_ctr;
                  next_st.wr.data   = byte_in;
                  next_st.addr_ctr  = st.addr_ctr + 5'h01;
                  next_st.state     = I_ACK;
                  next_st.after_ack = I_DATA;
                end
              endcase
            end
          end
        end
        I_ACK: begin
          if (scl_fall) begin
            next_st.ack_drive = !st.ack_drive;
            if (st.ack_drive) begin
              next_st.state = st.after_ack;
            end
          end
        end
        default: begin
          next_st.state = I_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st <= '{state: I_IDLE, after_ack: I_IDLE, scl_q: 1'b1, sda_q: 1'b1, default: '0};
    end else begin
      st <= next_st;
    end
  end

  assign sda_oe_o = st.ack_drive;
  assign wr_o     = st.wr;

endmodule : dacrp_i2c_rx

// ### core/dacrp_top.sv
// dac control register port: pin synchronisers, two link receivers and the register bank
`timescale 1ns/1ps
module dacrp_top (
  input  wire logic        core_clk_i,
  input  wire logic        arst_n_i,
  input  wire logic        hw_reset_n_i,
  input  wire logic        serial_mode_i,
  input  wire logic        i2c_mode_i,
  input  wire logic        chip_addr_pin_low_i,
  input  wire logic        chip_addr_pin_high_i,
  input  wire logic        serial_select_n_i,
  input  wire logic        serial_ctrl_clock_i,
  input  wire logic        serial_ctrl_data_in_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_o,
  input  wire logic        par_gradual_mute_i,
  input  wire logic        par_auto_clock_detect_i,
  input  wire logic [2:0]  par_audio_format_i,
  input  wire logic [1:0]  par_emphasis_sel_i,
  input  wire logic        par_slot_mode_256fs_i,
  output logic [7:0]       main_control_o,
  output logic [7:0]       filter_speed_control_o,
  output logic [7:0]       power_polarity_control_o,
  output logic [7:0]       left1_volume_o,
  output logic [7:0]       right1_volume_o,
  output logic [7:0]       left2_volume_o,
  output logic [7:0]       right2_volume_o,
  output logic [7:0]       left3_volume_o,
  output logic [7:0]       right3_volume_o,
  output logic [7:0]       output_polarity_o,
  output logic [7:0]       zero_flag1_select_o,
  output logic [7:0]       zero_flag2_select_o,
  output logic [7:0]       emphasis_enable_o,
  output logic             timing_reset_n_o
);

  localparam int unsigned NSYNC = 15;

  // every pin passes two flops; stage one feeds only stage two
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] sync1;
  logic [NSYNC-1:0] sync2;

  assign pin_raw = {hw_reset_n_i, serial_mode_i, i2c_mode_i, chip_addr_pin_low_i,
                    chip_addr_pin_high_i, serial_select_n_i, serial_ctrl_clock_i,
                    serial_ctrl_data_in_i, sda_i, par_gradual_mute_i,
                    par_auto_clock_detect_i, par_audio_format_i, par_slot_mode_256fs_i};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          sync1[gi] <= 1'b1;
          sync2[gi] <= 1'b1;
        end else begin
          sync1[gi] <= pin_raw[gi];
          sync2[gi] <= sync1[gi];
        end
      end
    end
  endgenerate

  // emphasis pins synchronised separately to keep the vector above readable
  logic [1:0] emph_s1;
  logic [1:0] emph_s2;

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      emph_s1 <= 2'h1;
      emph_s2 <= 2'h1;
    end else begin
      emph_s1 <= par_emphasis_sel_i;
      emph_s2 <= emph_s1;
    end
  end

  logic       s_hw_reset_n;
  logic       s_serial_mode;
  logic       s_i2c_mode;
  logic [1:0] s_chip_addr;
  logic       s_sel_n;
  logic       s_sclk;
  logic       s_sdat;
  logic       s_sda;
  logic       s_mute;
  logic       s_auto_clock_detect;
  logic [2:0] s_fmt;
  logic       s_slot_mode_256fs;

  assign {s_hw_reset_n, s_serial_mode, s_i2c_mode, s_chip_addr[0], s_chip_addr[1],
          s_sel_n, s_sclk, s_sdat, s_sda, s_mute, s_auto_clock_detect, s_fmt, s_slot_mode_256fs} = sync2;

  dacrp_pkg::dacrp_wr_t ser_wr;
  dacrp_pkg::dacrp_wr_t i2c_wr;
  logic                 i2c_sda_oe;

  dacrp_serial_rx u_serial_rx (
    .core_clk_i           (core_clk_i),
    .arst_n_i             (arst_n_i),
    .enable_i             (s_serial_mode && !s_i2c_mode && s_hw_reset_n),
    .chip_addr_pin_high_i (s_chip_addr[1]),
    .sel_n_i              (s_sel_n),
    .sclk_i               (s_sclk),
    .sdat_i               (s_sdat),
    .wr_o                 (ser_wr)
  );

  dacrp_i2c_rx u_i2c_rx (
    .core_clk_i  (core_clk_i),
    .arst_n_i    (arst_n_i),
    .enable_i    (s_serial_mode && s_i2c_mode && s_hw_reset_n),
    .chip_addr_i (s_chip_addr),
    .scl_i       (s_sclk),
    .sda_i       (s_sda),
    .sda_oe_o    (i2c_sda_oe),
    .wr_o        (i2c_wr)
  );

  typedef struct packed {
    logic [dacrp_pkg::REG_COUNT-1:0][7:0] regs;
    logic [7:0] out_main;
    logic [7:0] out_filter;
    logic [7:0] out_power;
    logic       timing_n;
    logic       sda_oe;
  } dacrp_top_st_t;

  dacrp_top_st_t st;
  dacrp_top_st_t next_st;

  function automatic logic [7:0] reg_default(input int unsigned idx);
    logic [7:0] v;
    v = dacrp_pkg::ZERO_RST;
    case (idx)
      0: v = dacrp_pkg::MAIN_CONTROL_RST;
      1: v = dacrp_pkg::FILTER_SPEED_CONTROL_RST;
      2: v = dacrp_pkg::POWER_POLARITY_CONTROL_RST;
      3, 4, 5, 6, 7, 8: v = dacrp_pkg::VOLUME_RST;
      9, 10: v = dacrp_pkg::RESERVED_RST;
      default: v = dacrp_pkg::ZERO_RST;
    endcase
    return v;
  endfunction : reg_default

  function automatic logic [7:0] reg_mask(input int unsigned idx);
    logic [7:0] m;
    m = 8'h00;
    case (idx)
      0: m = dacrp_pkg::MAIN_CONTROL_MASK;
      1: m = dacrp_pkg::FILTER_SPEED_CONTROL_MASK;
      2: m = dacrp_pkg::POWER_POLARITY_CONTROL_MASK;
      3, 4, 5, 6, 7, 8: m = dacrp_pkg::VOLUME_MASK;
      11, 12, 13: m = dacrp_pkg::LANE_SELECT_MASK;
      14: m = dacrp_pkg::EMPHASIS_ENABLE_MASK;
      default: m = 8'h00;
    endcase
    return m;
  endfunction : reg_mask

  dacrp_pkg::dacrp_wr_t wr;
  int unsigned          widx;

  always_comb begin
    next_st = st;
    // links are mutually exclusive by mode, so at most one strobe is live
    wr      = ser_wr.valid ? ser_wr : i2c_wr;
    widx    = 32'(wr.addr);
    if (!s_hw_reset_n) begin
      for (int i = 0; i < dacrp_pkg::REG_COUNT; i++) begin
        next_st.regs[i] = reg_default(i);
      end
    end else if (wr.valid && widx < dacrp_pkg::REG_COUNT) begin
      // no power or timing bit gates this write
      next_st.regs[widx] = wr.data & reg_mask(widx);
      // shared dac1 power-up bit: mirror into the other register
      if (widx == 32'(dacrp_pkg::MAIN_CONTROL_OFFS)) begin
        next_st.regs[2][dacrp_pkg::DAC1_POWER_UP_POS] =
          wr.data[dacrp_pkg::DAC1_POWER_UP_POS];
      end else if (widx == 32'(dacrp_pkg::POWER_POLARITY_CONTROL_OFFS)) begin
        next_st.regs[0][dacrp_pkg::DAC1_POWER_UP_POS] =
          wr.data[dacrp_pkg::DAC1_POWER_UP_POS];
      end
    end
    // writes to 0fh..1fh are dropped; the host is told not to make them
    next_st.out_main   = st.regs[0];
    next_st.out_filter = st.regs[1];
    next_st.out_power  = st.regs[2];
    if (!s_serial_mode) begin
      // parallel mode: only mute, emphasis, format, auto clock and 256fs slots
      next_st.out_main   = {s_auto_clock_detect, 1'b0, s_slot_mode_256fs, s_fmt, 1'b1, 1'b1};
      next_st.out_filter = {3'h0, 2'h0, emph_s2, s_mute};
      next_st.out_power  = dacrp_pkg::POWER_POLARITY_CONTROL_RST;
    end
    next_st.timing_n = s_hw_reset_n && next_st.out_main[dacrp_pkg::TIMING_RESET_BIT_POS];
    next_st.sda_oe   = i2c_sda_oe;
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st.regs[0]  <= dacrp_pkg::MAIN_CONTROL_RST;
      st.regs[1]  <= dacrp_pkg::FILTER_SPEED_CONTROL_RST;
      st.regs[2]  <= dacrp_pkg::POWER_POLARITY_CONTROL_RST;
      st.regs[3]  <= dacrp_pkg::VOLUME_RST;
      st.regs[4]  <= dacrp_pkg::VOLUME_RST;
      st.regs[5]  <= dacrp_pkg::VOLUME_RST;
      st.regs[6]  <= dacrp_pkg::VOLUME_RST;
      st.regs[7]  <= dacrp_pkg::VOLUME_RST;
      st.regs[8]  <= dacrp_pkg::VOLUME_RST;
      st.regs[9]  <= dacrp_pkg::RESERVED_RST;
      st.regs[10] <= dacrp_pkg::RESERVED_RST;
      st.regs[11] <= dacrp_pkg::ZERO_RST;
      st.regs[12] <= dacrp_pkg::ZERO_RST;
      st.regs[13] <= dacrp_pkg::ZERO_RST;
      st.regs[14] <= dacrp_pkg::ZERO_RST;
      st.out_main   <= dacrp_pkg::MAIN_CONTROL_RST;
      st.out_filter <= dacrp_pkg::FILTER_SPEED_CONTROL_RST;
      st.out_power  <= dacrp_pkg::POWER_POLARITY_CONTROL_RST;
      st.timing_n   <= 1'b0;
      st.sda_oe     <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign main_control_o           = st.out_main;
  assign filter_speed_control_o   = st.out_filter;
  assign power_polarity_control_o = st.out_power;
  assign left1_volume_o           = st.regs[3];
  assign right1_volume_o          = st.regs[4];
  assign left2_volume_o           = st.regs[5];
  assign right2_volume_o          = st.regs[6];
  assign left3_volume_o           = st.regs[7];
  assign right3_volume_o          = st.regs[8];
  assign output_polarity_o        = st.regs[11];
  assign zero_flag1_select_o      = st.regs[12];
  assign zero_flag2_select_o      = st.regs[13];
  assign emphasis_enable_o        = st.regs[14];
  assign timing_reset_n_o         = st.timing_n;
  // open-drain acknowledge: drive low only while enabled
  assign sda_o                    = 1'b0;
  assign sda_oe_o                 = st.sda_oe;

endmodule : dacrp_top

// ### tb/dacrp_assertions.sv
// concurrent checks on the dac control port pins and register outputs
`timescale 1ns/1ps
module dacrp_assertions (
  input  wire logic       core_clk_i,
  input  wire logic       arst_n_i,
  input  wire logic       hw_reset_n_i,
  input  wire logic       serial_mode_i,
  input  wire logic       i2c_mode_i,
  input  wire logic       serial_select_n_i,
  input  wire logic       par_gradual_mute_i,
  input  wire logic [1:0] par_emphasis_sel_i,
  input  logic            sda_oe_o,
  input  logic [7:0]      main_control_o,
  input  logic [7:0]      filter_speed_control_o,
  input  logic [7:0]      power_polarity_control_o,
  input  logic [7:0]      left1_volume_o,
  input  logic            timing_reset_n_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);

  sequence s_sel_low;
    (serial_mode_i && !i2c_mode_i && !serial_select_n_i)[*8];
  endsequence
  // select high long enough for any commit to have landed
  sequence s_ser_idle;
    (serial_mode_i && !i2c_mode_i && serial_select_n_i && hw_reset_n_i)[*8];
  endsequence
  sequence s_hw_low;
    (serial_mode_i && !hw_reset_n_i)[*6];
  endsequence

  property p_hw_def;
    s_hw_low |-> main_control_o == dacrp_pkg::MAIN_CONTROL_RST &&
      filter_speed_control_o == dacrp_pkg::FILTER_SPEED_CONTROL_RST &&
      left1_volume_o == dacrp_pkg::VOLUME_RST;
  endproperty
  a_hw_def: assert property (p_hw_def)
    else $error("defaults not loaded while reset pin low");
  property p_commit;
    s_sel_low |-> $stable(left1_volume_o) && $stable(main_control_o);
  endproperty
  a_commit: assert property (p_commit)
    else $error("register changed while select low");
  property p_ser_ignore;
    s_ser_idle |-> $stable(filter_speed_control_o) && $stable(main_control_o);
  endproperty
  a_ser_ignore: assert property (p_ser_ignore)
    else $error("register moved with no frame in serial mode");
  property p_mirror;
    power_polarity_control_o[1] == main_control_o[1];
  endproperty
  a_mirror: assert property (p_mirror)
    else $error("dac1 power bit differs between registers");
  property p_timing;
    (hw_reset_n_i && $stable(main_control_o[0]))[*5] |-> timing_reset_n_o == main_control_o[0];
  endproperty
  a_timing: assert property (p_timing)
    else $error("timing reset output does not follow its bit");
  property p_ack_win;
    $rose(sda_oe_o) |-> sda_oe_o[*6];
  endproperty
  a_ack_win: assert property (p_ack_win)
    else $error("acknowledge too short");
  property p_quiet;
    (!i2c_mode_i)[*4] |-> !sda_oe_o;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("data line driven outside two-wire mode");
  property p_par;
    (!serial_mode_i && $stable({par_emphasis_sel_i, par_gradual_mute_i}))[*8] |->
      filter_speed_control_o == {5'h00, par_emphasis_sel_i, par_gradual_mute_i};
  endproperty
  a_par: assert property (p_par)
    else $error("parallel pins not shown in parallel mode");
endmodule : dacrp_assertions

bind dacrp_top dacrp_assertions u_chk (.core_clk_i, .arst_n_i, .hw_reset_n_i, .serial_mode_i,
  .i2c_mode_i, .serial_select_n_i, .par_gradual_mute_i, .par_emphasis_sel_i, .sda_oe_o,
  .main_control_o, .filter_speed_control_o, .power_polarity_control_o, .left1_volume_o,
  .timing_reset_n_o);

// ### tb/dacrp_host_model.sv
// host model: drives 3-wire frames and two-wire write sequences
`timescale 1ns/1ps
module dacrp_host_model (
  input  wire logic sda_i,
  output logic      sel_n_o,
  output logic      sclk_o,
  output logic      sdat_o,
  output logic      sda_low_o
);
  initial begin
    sel_n_o = 1'b1;
    sclk_o = 1'b1;
    sdat_o = 1'b0;
    sda_low_o = 1'b0;
  end

  // a real host keeps its clock under the limit; the bench runs faster to stay short
  task automatic ser(input logic [15:0] f);
    // calls start on a core clock edge; move off it so pins never race the samplers
    #3;
    sel_n_o = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      #32 sclk_o = 1'b0;
      sdat_o = f[i];
      #32 sclk_o = 1'b1;
    end
    #32 sel_n_o = 1'b1;
    // released data line must not keep looking valid
    sdat_o = ~sdat_o;
    // select must be seen high long enough to commit before another frame begins
    #61;
  endtask : ser

  task automatic i2c(input logic [39:0] b, input int n, output logic [4:0] ack);
    ack = 5'h00;
    #3;
    sda_low_o = 1'b1;
    #32 sclk_o = 1'b0;
    for (int k = 0; k < n; k++) begin
      for (int i = 7; i >= 0; i--) begin
        #16 sda_low_o = ~b[8 * (n - 1 - k) + i];
        #16 sclk_o = 1'b1;
        #32 sclk_o = 1'b0;
      end
      #16 sda_low_o = 1'b0;
      #16 sclk_o = 1'b1;
      #16 ack[k] = ~sda_i;
      #16 sclk_o = 1'b0;
    end
    #16 sda_low_o = 1'b1;
    #16 sclk_o = 1'b1;
    #16 sda_low_o = 1'b0;
    #29;
  endtask : i2c
endmodule : dacrp_host_model

// ### tb/test_dac_control_register_port.sv
// testbench: random and corner writes over both links, register outputs checked
`timescale 1ns/1ps
module test_dac_control_register_port;
  logic clk = 0, rst_n = 0, hw_n = 0, ser_m = 1, i2c_m = 0, cad_lo = 0, cad_hi = 1;
  logic mute = 0, auto_clock_detect = 0, s256 = 0;
  logic [2:0] fmt = 0;
  logic [1:0] emph = 0;
  logic sel_n, sclk, sdat, sda_low, sda_oe, tr_n;
  logic [7:0] q [15];
  logic [7:0] e [15];
  int fail_count = 0, compares = 0;
  wire sda = !(sda_low | sda_oe);

  always #4 clk = ~clk;

  dacrp_host_model m (.sda_i(sda), .sel_n_o(sel_n), .sclk_o(sclk), .sdat_o(sdat),
    .sda_low_o(sda_low));
  dacrp_top DUT (.core_clk_i(clk), .arst_n_i(rst_n), .hw_reset_n_i(hw_n),
    .serial_mode_i(ser_m), .i2c_mode_i(i2c_m), .chip_addr_pin_low_i(cad_lo),
    .chip_addr_pin_high_i(cad_hi), .serial_select_n_i(sel_n), .serial_ctrl_clock_i(sclk),
    .serial_ctrl_data_in_i(sdat), .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe),
    .par_gradual_mute_i(mute), .par_auto_clock_detect_i(auto_clock_detect), .par_audio_format_i(fmt),
    .par_emphasis_sel_i(emph), .par_slot_mode_256fs_i(s256), .main_control_o(q[0]),
    .filter_speed_control_o(q[1]), .power_polarity_control_o(q[2]), .left1_volume_o(q[3]),
    .right1_volume_o(q[4]), .left2_volume_o(q[5]), .right2_volume_o(q[6]),
    .left3_volume_o(q[7]), .right3_volume_o(q[8]), .output_polarity_o(q[11]),
    .zero_flag1_select_o(q[12]), .zero_flag2_select_o(q[13]), .emphasis_enable_o(q[14]),
    .timing_reset_n_o(tr_n));

  function automatic logic [7:0] wm(input int a);
    case (a)
      0: return dacrp_pkg::MAIN_CONTROL_MASK;
      1: return dacrp_pkg::FILTER_SPEED_CONTROL_MASK;
      2: return dacrp_pkg::POWER_POLARITY_CONTROL_MASK;
      9, 10: return 8'h00;
      11, 12, 13: return dacrp_pkg::LANE_SELECT_MASK;
      14: return dacrp_pkg::EMPHASIS_ENABLE_MASK;
      default: return dacrp_pkg::VOLUME_MASK;
    endcase
  endfunction : wm

  function automatic void dflt();
    for (int a = 0; a < 15; a++)
      e[a] = (a == 0) ? 8'h8b : (a == 1) ? 8'h02 : (a == 2) ? 8'h62 : (a < 9) ? 8'hff : 8'h00;
  endfunction : dflt

  function automatic void put(input int a, input logic [7:0] d);
    e[a] = (e[a] & ~wm(a)) | (d & wm(a));
    if (a == 0 || a == 2) begin
      e[0][1] = d[1];
      e[2][1] = d[1];
    end
  endfunction : put

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_all();
    repeat (12) @(posedge clk);
    for (int a = 0; a < 15; a++)
      if (a != 9 && a != 10) chk(q[a], e[a]);
    chk({7'h00, tr_n}, {7'h00, e[0][0]});
  endtask : chk_all

  task automatic hwr();
    @(posedge clk) hw_n <= 1'b0;
    repeat (8) @(posedge clk);
    hw_n <= 1'b1;
    dflt();
    repeat (8) @(posedge clk);
  endtask : hwr

  task automatic results();
    $display("comparisons %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : results

  initial begin
    #600us;
    fail_count++;
    results();
  end

  initial begin
    int a;
    logic [7:0] d;
    logic [4:0] ack;
    void'($urandom(32'h34894993));
    dflt();
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    hw_n <= 1'b1;
    chk_all();
    for (int n = 0; n < 40; n++) begin
      a = $urandom_range(14);
      d = 8'($urandom);
      @(posedge clk) {cad_lo, cad_hi, mute, auto_clock_detect, s256, fmt, emph} <= 10'($urandom);
      repeat (4) @(posedge clk);
      m.ser({cad_hi, 2'b11, 5'(a), d});
      put(a, d);
      chk_all();
    end
    m.ser({cad_hi, 2'b11, 5'h00, 8'h8a});
    put(0, 8'h8a);
    m.ser({cad_hi, 2'b11, 5'h04, 8'h5a});
    put(4, 8'h5a);
    chk_all();
    for (int k = 0; k < 3; k++) begin
      m.ser({{cad_hi, 2'b11} ^ (3'b100 >> k), 5'h03, 8'h00});
      chk_all();
    end
    hwr();
    chk_all();
    @(posedge clk) i2c_m <= 1'b1;
    hwr();
    m.i2c({dacrp_pkg::I2C_ADDR_PREFIX, cad_hi, cad_lo, 1'b0, 8'h0c, 24'h8c_54_0e}, 5, ack);
    put(12, 8'h8c);
    put(13, 8'h54);
    put(14, 8'h0e);
    chk({3'h0, ack}, 8'h1f);
    chk_all();
    for (int n = 0; n < 10; n++) begin
      a = $urandom_range(14);
      d = 8'($urandom);
      @(posedge clk) cad_lo <= 1'($urandom);
      repeat (4) @(posedge clk);
      m.i2c({16'h0, dacrp_pkg::I2C_ADDR_PREFIX, cad_hi, cad_lo, 1'b0, 3'b000, 5'(a), d}, 3, ack);
      put(a, d);
      chk({3'h0, ack}, 8'h07);
      chk_all();
    end
    m.i2c({16'h0, dacrp_pkg::I2C_ADDR_PREFIX, ~cad_hi, cad_lo, 1'b0, 16'h0300}, 3, ack);
    chk({3'h0, ack}, 8'h00);
    m.i2c({32'h0, dacrp_pkg::I2C_ADDR_PREFIX, cad_hi, cad_lo, 1'b1}, 1, ack);
    chk({3'h0, ack}, 8'h00);
    chk_all();
    @(posedge clk) ser_m <= 1'b0;
    hwr();
    @(posedge clk) {mute, auto_clock_detect, s256, fmt, emph} <= 8'($urandom);
    repeat (12) @(posedge clk);
    chk(q[1], {5'h00, emph, mute});
    chk(q[0], {auto_clock_detect, 1'b0, s256, fmt, 2'b11});
    results();
  end
endmodule : test_dac_control_register_port
